// ===== tk_pkg.sv
// tk_pkg: shared constants of the timekeeper with stopwatch
// assumes a 125 MHz system clock and a 32-bit avalon-mm register slave
package tk_pkg;

	// ----------------------------------------------------------------
	// clock and time base
	// ----------------------------------------------------------------
	localparam int TK_CLK_HZ = 125_000_000;
	localparam int TK_TICK_S = 1;
	localparam int TK_TICK_CYC = TK_CLK_HZ * TK_TICK_S;
	localparam int TK_DIV_W = 27;

	// ----------------------------------------------------------------
	// counter widths and limits
	// ----------------------------------------------------------------
	localparam int TK_CNT_W = 7;
	localparam logic [6:0] TK_SEC_MAX = 7'h3B;
	localparam logic [6:0] TK_MIN_MAX = 7'h3B;
	localparam logic [6:0] TK_HR_MAX = 7'h17;
	localparam logic [6:0] TK_SWMIN_MAX = 7'h63;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam int TK_ADDR_W = 6;
	localparam logic [5:0] TK_OFS_CTRL = 6'h00;
	localparam logic [5:0] TK_OFS_SETVAL = 6'h04;
	localparam logic [5:0] TK_OFS_CMD = 6'h08;
	localparam logic [5:0] TK_OFS_CUR = 6'h0C;
	localparam logic [5:0] TK_OFS_PRESET = 6'h10;
	localparam logic [5:0] TK_OFS_DISP = 6'h14;
	localparam logic [5:0] TK_OFS_SW = 6'h18;
	localparam logic [5:0] TK_OFS_STATUS = 6'h1C;
	localparam logic [5:0] TK_OFS_MASK = 6'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TK_CTRL_CORR = 0;
	localparam int TK_CTRL_DISP_PRE = 1;
	localparam int TK_CTRL_EXT_TB = 2;
	localparam int TK_CTRL_TGT_PRE = 3;
	localparam int TK_CMD_ENTER = 0;
	localparam int TK_HMS_SEC_LSB = 0;
	localparam int TK_HMS_MIN_LSB = 8;
	localparam int TK_HMS_HR_LSB = 16;
	localparam int TK_SW_BLANK = 16;
	localparam int TK_EV_TICK = 0;
	localparam int TK_EV_ANN = 1;
	localparam int TK_EV_AUTO = 2;
	localparam int TK_EV_W = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] TK_CTRL_RST = 4'h0;
	localparam logic [2:0] TK_MASK_RST = 3'h0;
	localparam logic [6:0] TK_CNT_RST = 7'h00;

	// ----------------------------------------------------------------
	// stopwatch states
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		TK_SW_IDLE = 3'b001,
		TK_SW_RUN = 3'b010,
		TK_SW_HOLD = 3'b100
	} tk_sw_state_t;

endpackage

// ===== tk_sync2.sv
// tk_sync2: two-flop synchroniser for a group of independent levels
// assumes each bit is a slow level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module tk_sync2
#(
	parameter int W = 1
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			q <= '0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // tk_sync2
`default_nettype wire

// ===== tk_wrap_cnt.sv
// tk_wrap_cnt: loadable counter from zero to maxv, wrapping to zero
// assumes synchronous reset release by the caller
`timescale 1ns/10ps
`default_nettype none
module tk_wrap_cnt
	import tk_pkg::*;
#(
	parameter logic [6:0] MAXV = 7'h3B
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [6:0] load_val,
	input wire logic inc,
	output logic [6:0] val_r,
	output logic wrap
);
	assign wrap = inc && (val_r == MAXV);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			val_r <= TK_CNT_RST;
		else if (load)
			val_r <= (load_val > MAXV) ? MAXV : load_val;
		else if (wrap)
			val_r <= TK_CNT_RST;
		else if (inc)
			val_r <= val_r + 7'h01;
	end
endmodule // tk_wrap_cnt
`default_nettype wire

// ===== tk_timekeeper.sv
// tk_timekeeper: time-of-day clock, preset announcement and stopwatch
// assumes avalon-mm master on clk_sys; panel and command pins asynchronous
`timescale 1ns/10ps
`default_nettype none
module tk_timekeeper
	import tk_pkg::*;
#(
	parameter int TICK_CYCLES = TK_TICK_CYC
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_pulse,
	input wire logic sw_button,
	input wire logic cmd_engine_fire,
	input wire logic cmd_engine_cutoff,
	input wire logic flag_maneuver,
	input wire logic cmd_touchdown,
	input wire logic flag_descent,
	output logic [4:0] disp_hours,
	output logic [5:0] disp_min,
	output logic [5:0] disp_sec,
	output logic [6:0] sw_min,
	output logic [5:0] sw_sec,
	output logic sw_blank,
	output logic announce,
	output logic irq
);
	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic rst_m_r;
	logic rst_s_n;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_m_r <= 1'b0;
			rst_s_n <= 1'b0;
		end
		else
		begin
			rst_m_r <= 1'b1;
			rst_s_n <= rst_m_r;
		end
	end

	logic [6:0] pin_s;
	logic [6:0] pin_d_r;
	logic [6:0] pin_rise;

	tk_sync2 #(.W(7)) u_sync
	(
		.clk_sys(clk_sys),
		.rst_n(rst_s_n),
		.d({flag_descent, cmd_touchdown, flag_maneuver, cmd_engine_cutoff,
			cmd_engine_fire, sw_button, ext_pulse}),
		.q(pin_s)
	);

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
			pin_d_r <= 7'h00;
		else
			pin_d_r <= pin_s;
	end

	assign pin_rise = pin_s & ~pin_d_r;

	// ----------------------------------------------------------------
	// bus slave: one wait cycle, then answer
	// ----------------------------------------------------------------
	logic done_r;
	logic acc;
	logic wr_acc;
	logic rd_acc;

	assign avs_waitrequest = (avs_read || avs_write) && !done_r;
	assign acc = (avs_read || avs_write) && done_r;
	assign wr_acc = acc && avs_write;
	assign rd_acc = acc && avs_read;

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
			done_r <= 1'b0;
		else
			done_r <= (avs_read || avs_write) && !done_r;
	end

	logic [3:0] ctrl_r;
	logic [20:0] setval_r;
	logic [2:0] mask_r;
	logic enter;

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			ctrl_r <= TK_CTRL_RST;
			setval_r <= 21'h000000;
			mask_r <= TK_MASK_RST;
		end
		else if (wr_acc)
		begin
			if (avs_address == TK_OFS_CTRL)
				ctrl_r <= avs_writedata[3:0];
			if (avs_address == TK_OFS_SETVAL)
				setval_r <= avs_writedata[20:0];
			if (avs_address == TK_OFS_MASK)
				mask_r <= avs_writedata[2:0];
		end
	end

	// enter only acts in correction mode
	assign enter = wr_acc && (avs_address == TK_OFS_CMD)
		&& avs_writedata[TK_CMD_ENTER] && ctrl_r[TK_CTRL_CORR];

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	logic [TK_DIV_W-1:0] div_r;
	logic int_tick;
	logic tick;
	logic run_tick;

	// exact division: internal drift is that of the clock source only
	assign int_tick = (div_r == TK_DIV_W'(TICK_CYCLES - 1));

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
			div_r <= '0;
		else if (int_tick)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end

	// external pulse from the timing unit, one tick per rising edge
	assign tick = ctrl_r[TK_CTRL_EXT_TB] ? pin_rise[0] : int_tick;
	assign run_tick = tick && !ctrl_r[TK_CTRL_CORR];

	// ----------------------------------------------------------------
	// current time and preset
	// ----------------------------------------------------------------
	logic [6:0] cur_s;
	logic [6:0] cur_m;
	logic [6:0] cur_h;
	logic s_wrap;
	logic m_wrap;
	logic ld_cur;

	assign ld_cur = enter && !ctrl_r[TK_CTRL_TGT_PRE];

	tk_wrap_cnt #(.MAXV(TK_SEC_MAX)) u_cur_s
	(
		.clk_sys(clk_sys),
		.rst_n(rst_s_n),
		.load(ld_cur),
		.load_val({1'b0, setval_r[TK_HMS_SEC_LSB +: 6]}),
		.inc(run_tick),
		.val_r(cur_s),
		.wrap(s_wrap)
	);

	tk_wrap_cnt #(.MAXV(TK_MIN_MAX)) u_cur_m
	(
		.clk_sys(clk_sys),
		.rst_n(rst_s_n),
		.load(ld_cur),
		.load_val({1'b0, setval_r[TK_HMS_MIN_LSB +: 6]}),
		.inc(s_wrap),
		.val_r(cur_m),
		.wrap(m_wrap)
	);

	tk_wrap_cnt #(.MAXV(TK_HR_MAX)) u_cur_h
	(
		.clk_sys(clk_sys),
		.rst_n(rst_s_n),
		.load(ld_cur),
		.load_val({2'b00, setval_r[TK_HMS_HR_LSB +: 5]}),
		.inc(m_wrap),
		.val_r(cur_h),
		.wrap()
	);

	logic [20:0] cur_w;
	logic [20:0] pre_r;

	assign cur_w = {cur_h[4:0], 2'b00, cur_m[5:0], 2'b00, cur_s[5:0]};

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
			pre_r <= 21'h000000;
		else if (enter && ctrl_r[TK_CTRL_TGT_PRE])
			pre_r <= setval_r & 21'h1F3F3F;
	end

	logic ann_r;
	logic ann_rise;

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
			ann_r <= 1'b0;
		else
			ann_r <= (cur_w == pre_r);
	end

	assign ann_rise = (cur_w == pre_r) && !ann_r;
	assign announce = ann_r;

	// ----------------------------------------------------------------
	// display selection
	// ----------------------------------------------------------------
	logic [20:0] disp_w;

	assign disp_w = ctrl_r[TK_CTRL_DISP_PRE] ? pre_r : cur_w;

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			disp_hours <= 5'h00;
			disp_min <= 6'h00;
			disp_sec <= 6'h00;
		end
		else
		begin
			disp_hours <= disp_w[TK_HMS_HR_LSB +: 5];
			disp_min <= disp_w[TK_HMS_MIN_LSB +: 6];
			disp_sec <= disp_w[TK_HMS_SEC_LSB +: 6];
		end
	end

	// ----------------------------------------------------------------
	// stopwatch control
	// ----------------------------------------------------------------
	tk_sw_state_t sw_st_r;
	tk_sw_state_t sw_st_nxt;
	logic a_fire;
	logic a_stop;
	logic auto_ev;
	logic sw_clr;

	assign a_fire = pin_rise[2];
	assign a_stop = (pin_rise[3] && pin_s[4])
		|| (pin_rise[5] && pin_s[6]);
	assign auto_ev = a_fire || a_stop;

	always_comb
	begin
		sw_st_nxt = sw_st_r;
		if (a_fire)
			sw_st_nxt = TK_SW_RUN;
		else if (a_stop)
			sw_st_nxt = (sw_st_r == TK_SW_IDLE) ? TK_SW_IDLE : TK_SW_HOLD;
		else if (pin_rise[1])
		begin
			unique case (sw_st_r)
				TK_SW_IDLE: sw_st_nxt = TK_SW_RUN;
				TK_SW_RUN: sw_st_nxt = TK_SW_HOLD;
				TK_SW_HOLD: sw_st_nxt = TK_SW_IDLE;
				default: sw_st_nxt = TK_SW_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
			sw_st_r <= TK_SW_IDLE;
		else
			sw_st_r <= sw_st_nxt;
	end

	// clear on fire, or on the button press that blanks
	assign sw_clr = a_fire || (sw_st_nxt == TK_SW_IDLE
		&& sw_st_r != TK_SW_IDLE);

	logic [6:0] sws_v;
	logic [6:0] swm_v;
	logic sws_wrap;

	tk_wrap_cnt #(.MAXV(TK_SEC_MAX)) u_sw_s
	(
		.clk_sys(clk_sys),
		.rst_n(rst_s_n),
		.load(sw_clr),
		.load_val(TK_CNT_RST),
		.inc(tick && sw_st_r == TK_SW_RUN),
		.val_r(sws_v),
		.wrap(sws_wrap)
	);

	tk_wrap_cnt #(.MAXV(TK_SWMIN_MAX)) u_sw_m
	(
		.clk_sys(clk_sys),
		.rst_n(rst_s_n),
		.load(sw_clr),
		.load_val(TK_CNT_RST),
		.inc(sws_wrap),
		.val_r(swm_v),
		.wrap()
	);

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			sw_min <= 7'h00;
			sw_sec <= 6'h00;
			sw_blank <= 1'b1;
		end
		else
		begin
			sw_min <= swm_v;
			sw_sec <= sws_v[5:0];
			sw_blank <= (sw_st_r == TK_SW_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// interrupt status, cleared by reading; a new event wins
	// ----------------------------------------------------------------
	logic [2:0] stat_r;
	logic [2:0] ev;

	assign ev = {auto_ev, ann_rise, tick};

	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
			stat_r <= 3'h0;
		else if (rd_acc && avs_address == TK_OFS_STATUS)
			// clear only what the read reported; later events stay
			stat_r <= ev | (stat_r & ~avs_readdata[2:0]);
		else
			stat_r <= stat_r | ev;
	end

	assign irq = |(stat_r & mask_r);

	// ----------------------------------------------------------------
	// read data, loaded in the wait cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
			avs_readdata <= 32'h00000000;
		else if (avs_read && !done_r)
		begin
			unique case (avs_address)
				TK_OFS_CTRL: avs_readdata <= {28'h0000000, ctrl_r};
				TK_OFS_SETVAL: avs_readdata <= {11'h000, setval_r};
				TK_OFS_CUR: avs_readdata <= {11'h000, cur_w};
				TK_OFS_PRESET: avs_readdata <= {11'h000, pre_r};
				TK_OFS_DISP: avs_readdata <= {11'h000, disp_w};
				TK_OFS_SW: avs_readdata <= {15'h0000,
					sw_st_r == TK_SW_IDLE, 1'b0, swm_v, 2'b00, sws_v[5:0]};
				TK_OFS_STATUS: avs_readdata <= {29'h00000000, stat_r};
				TK_OFS_MASK: avs_readdata <= {29'h00000000, mask_r};
				default: avs_readdata <= 32'h00000000;
			endcase
		end
	end
endmodule // tk_timekeeper
`default_nettype wire

// ===== tk_asserts.sv
// tk_asserts: port-level checks of the timekeeper, bound to its top
// assumes a single clk_sys domain and rst_n active low
`timescale 1ns/10ps
`default_nettype none
module tk_chk
#(
	parameter int TICK_CYCLES = 16
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic cmd_engine_fire,
	input wire logic cmd_engine_cutoff,
	input wire logic flag_maneuver,
	input wire logic cmd_touchdown,
	input wire logic flag_descent,
	input wire logic [4:0] disp_hours,
	input wire logic [5:0] disp_min,
	input wire logic [5:0] disp_sec,
	input wire logic [6:0] sw_min,
	input wire logic [5:0] sw_sec,
	input wire logic sw_blank
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// stopwatch frozen for 24 cycles, longer than one bench tick (16 or 20 cycles)
	// ------------------------------------------------------------
	sequence s_frozen;
		($stable(sw_sec) && $stable(sw_min))[*8];
	endsequence
	sequence s_stopped;
		s_frozen ##1 s_frozen ##1 s_frozen;
	endsequence
	property p_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	property p_idle;
		!avs_read && !avs_write |-> !avs_waitrequest;
	endproperty
	property p_rdata;
		!avs_read |=> $stable(avs_readdata);
	endproperty
	property p_blank;
		sw_blank |-> sw_min == 7'h00 && sw_sec == 6'h00;
	endproperty
	property p_roll;
		$past(sw_sec) == 6'h3B && sw_sec == 6'h00 && sw_min != 7'h00
			|-> sw_min == $past(sw_min) + 7'h01;
	endproperty
	property p_range;
		disp_sec <= 6'h3B && disp_min <= 6'h3B && disp_hours <= 5'h17;
	endproperty
	property p_fire;
		$rose(cmd_engine_fire)
			|-> ##[2:8] (sw_sec == 6'h00 && sw_min == 7'h00 && !sw_blank);
	endproperty
	property p_cut;
		$rose(cmd_engine_cutoff) && flag_maneuver |-> ##8 s_stopped;
	endproperty
	property p_touch;
		$rose(cmd_touchdown) && flag_descent |-> ##8 s_stopped;
	endproperty
	a_wait: assert property (p_wait)
		else $error("waitrequest held past one wait state");
	a_idle: assert property (p_idle)
		else $error("waitrequest high with no request");
	a_rdata: assert property (p_rdata)
		else $error("readdata changed without a read");
	a_blank: assert property (p_blank)
		else $error("blank stopwatch not cleared");
	a_roll: assert property (p_roll)
		else $error("stopwatch minute not advanced at rollover");
	a_range: assert property (p_range)
		else $error("displayed time out of range");
	a_fire: assert property (p_fire)
		else $error("engine fire did not clear and restart");
	a_cut: assert property (p_cut)
		else $error("cutoff with maneuver did not stop");
	a_touch: assert property (p_touch)
		else $error("touchdown with descent did not stop");
endmodule // tk_chk
bind tk_timekeeper tk_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);
`default_nettype wire

// ===== tk_partner.sv
// tk_partner: timing unit pulse source and automatic command source
// assumes the bench calls cmd() and sets flg_r and pulse_en
`timescale 1ns/10ps
`default_nettype none
module tk_partner
#(
	parameter int PULSE_CYC = 20
)
(
	input wire logic clk_sys,
	output logic ext_pulse,
	output logic cmd_engine_fire,
	output logic cmd_engine_cutoff,
	output logic cmd_touchdown,
	output logic flag_maneuver,
	output logic flag_descent
);
	logic pulse_en = 1'b0;
	logic [2:0] cmd_r = 3'h0;
	logic [1:0] flg_r = 2'h0;
	int pcnt = 0;
	assign {cmd_touchdown, cmd_engine_cutoff, cmd_engine_fire} = cmd_r;
	assign {flag_descent, flag_maneuver} = flg_r;
	// one pulse every PULSE_CYC cycles, four cycles wide, only while enabled
	always @(posedge clk_sys)
	begin
		pcnt <= (pcnt == PULSE_CYC - 1) ? 0 : pcnt + 1;
		ext_pulse <= pulse_en && pcnt < 4;
	end
	task automatic cmd(input int k);
		@(posedge clk_sys);
		cmd_r[k] <= 1'b1;
		repeat (4) @(posedge clk_sys);
		cmd_r[k] <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule // tk_partner
`default_nettype wire

// ===== tb_top.sv
// tb_top: self-checking bench of the timekeeper
// assumes tk_partner drives pulse and command pins
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import tk_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_n;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata, d;
	logic avs_waitrequest, ext_pulse, sw_button;
	logic cmd_engine_fire, cmd_engine_cutoff, cmd_touchdown;
	logic flag_maneuver, flag_descent, sw_blank, announce, irq;
	logic [4:0] disp_hours;
	logic [5:0] disp_min, disp_sec, sw_sec, v;
	logic [6:0] sw_min;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	always #4 clk_sys = ~clk_sys;
	tk_timekeeper #(.TICK_CYCLES(16)) dut_u (.*);
	tk_partner #(.PULSE_CYC(20)) partner_u (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk_sys);
		while (avs_waitrequest)
			@(posedge clk_sys);
		d = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(d, exp);
	endtask
	task automatic wchg;
		v = disp_sec;
		for (int i = 0; i < 300 && v === disp_sec; i++)
			@(posedge clk_sys);
	endtask
	task automatic moving(input logic exp);
		logic [5:0] s;
		s = sw_sec;
		wt(40);
		chk(sw_sec !== s, exp);
	endtask
	task automatic press;
		sw_button <= 1'b1;
		wt(4);
		sw_button <= 1'b0;
		wt(6);
	endtask
	task automatic stop_test;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task t_clock;
		rdc(TK_OFS_CTRL, 32'h0);
		rdc(TK_OFS_MASK, 32'h0);
		rdc(6'h3C, 32'h0);
		bus(1'b1, TK_OFS_CTRL, 32'h1);
		bus(1'b1, TK_OFS_SETVAL, 32'h00173B3A);
		bus(1'b1, TK_OFS_CMD, 32'h1);
		rdc(TK_OFS_CUR, 32'h00173B3A);
		wt(40);
		rdc(TK_OFS_CUR, 32'h00173B3A);
		bus(1'b1, TK_OFS_CTRL, 32'h0);
		wchg;
		chk({disp_hours, disp_min, disp_sec}, 17'h17EFB);
		wchg;
		chk({disp_hours, disp_min, disp_sec}, 17'h0);
		bus(1'b1, TK_OFS_SETVAL, 32'h00050505);
		bus(1'b1, TK_OFS_CMD, 32'h1);
		bus(1'b0, TK_OFS_CUR, 32'h0);
		chk(d[20:8], 13'h0);
		$display("clock test done");
	endtask
	task t_preset;
		bus(1'b0, TK_OFS_STATUS, 32'h0);
		bus(1'b1, TK_OFS_CTRL, 32'hB);
		bus(1'b1, TK_OFS_SETVAL, 32'h0000000A);
		bus(1'b1, TK_OFS_CMD, 32'h1);
		rdc(TK_OFS_PRESET, 32'h0000000A);
		wt(3);
		chk(disp_sec, 6'h0A);
		rdc(TK_OFS_DISP, 32'h0000000A);
		rdc(TK_OFS_SETVAL, 32'h0000000A);
		bus(1'b1, TK_OFS_CTRL, 32'h0);
		for (int i = 0; i < 400 && announce !== 1'b1; i++)
			@(posedge clk_sys);
		chk(announce, 1'b1);
		chk(irq, 1'b0);
		bus(1'b1, TK_OFS_MASK, 32'h2);
		wt(1);
		chk(irq, 1'b1);
		bus(1'b0, TK_OFS_STATUS, 32'h0);
		chk(d[1], 1'b1);
		wt(2);
		chk(irq, 1'b0);
		$display("preset test done");
	endtask
	task t_ext;
		bus(1'b1, TK_OFS_CTRL, 32'h4);
		bus(1'b0, TK_OFS_CUR, 32'h0);
		wt(50);
		rdc(TK_OFS_CUR, d);
		partner_u.pulse_en <= 1'b1;
		wchg;
		partner_u.pulse_en <= 1'b0;
		chk(disp_sec, v + 6'h01);
		bus(1'b1, TK_OFS_CTRL, 32'h0);
		$display("time base test done");
	endtask
	task t_sw;
		rdc(TK_OFS_SW, 32'h00010000);
		press;
		moving(1'b1);
		press;
		moving(1'b0);
		press;
		chk({sw_blank, sw_min, sw_sec}, 14'h2000);
		partner_u.cmd(0);
		chk(sw_blank, 1'b0);
		moving(1'b1);
		bus(1'b0, TK_OFS_STATUS, 32'h0);
		chk(d[2], 1'b1);
		chk(d[0], 1'b1);
		partner_u.cmd(1);
		moving(1'b1);
		bus(1'b0, TK_OFS_STATUS, 32'h0);
		chk(d[2], 1'b0);
		partner_u.flg_r <= 2'h1;
		partner_u.cmd(1);
		moving(1'b0);
		partner_u.cmd_r[0] <= 1'b1;
		sw_button <= 1'b1;
		wt(4);
		partner_u.cmd_r[0] <= 1'b0;
		sw_button <= 1'b0;
		wt(8);
		chk(sw_blank, 1'b0);
		moving(1'b1);
		partner_u.cmd(2);
		moving(1'b1);
		partner_u.flg_r <= 2'h2;
		partner_u.cmd(2);
		moving(1'b0);
		partner_u.cmd(0);
		for (int i = 0; i < 1100 && sw_min === 7'h00; i++)
			@(posedge clk_sys);
		chk({sw_min, sw_sec}, 13'h0040);
		$display("stopwatch test done");
	endtask
	initial
	begin
		rst_n <= 1'b0;
		avs_address <= 6'h00;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= 32'h0;
		sw_button <= 1'b0;
		wt(12);
		rst_n <= 1'b1;
		wt(3);
		t_clock;
		t_preset;
		t_ext;
		t_sw;
		stop_test;
	end
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			miscompares++;
			stop_test;
		end
	end
endmodule // tb_top
`default_nettype wire
